// ### hdl/ssoc_pin_latch.sv
// File: port latches of the two candidate pins
`timescale 1ns/1ps
module ssoc_pin_latch
    import ssoc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire ssoc_pin_s i_upd,
    input wire logic i_sw_first_wr,
    input wire logic i_sw_first_val,
    input wire logic i_sw_second_wr,
    input wire logic i_sw_second_val,
    output logic o_first_candidate_port_pin,
    output logic o_second_candidate_port_pin
);
    // Latch state
    logic first_q, first_d;
    logic second_q, second_d;

    // --------------------------------------------------------------
    // Next latch values
    // --------------------------------------------------------------
    // Wake update wins over a port write in the same cycle
    always_comb begin
        first_d = first_q;
        second_d = second_q;
        if (i_sw_first_wr) begin
            first_d = i_sw_first_val;
        end
        if (i_sw_second_wr) begin
            second_d = i_sw_second_val;
        end
        if (i_upd.load) begin
            // Route to selected pin drive level
            if (i_upd.select == SSOC_SEL_SECOND) begin
                second_d = i_upd.level;
            end else begin
                first_d = i_upd.level;
            end
        end
    end

    // Register the latches
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            first_q <= 1'b0;
            second_q <= 1'b0;
        end else begin
            first_q <= first_d;
            second_q <= second_d;
        end
    end

    assign o_first_candidate_port_pin = first_q;
    assign o_second_candidate_port_pin = second_q;

    a_second_route: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        i_upd.load && i_upd.select |=> second_q == $past(i_upd.level))
        else $error("second pin not loaded");
    a_first_route: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        i_upd.load && !i_upd.select |=> first_q == $past(i_upd.level))
        else $error("first pin not loaded");
endmodule : ssoc_pin_latch

// ### hdl/ssoc_top.sv
// File: stop status output control block, register and wake logic
`timescale 1ns/1ps
module ssoc_top
    import ssoc_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0 // Select bit reserved when set
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic [19:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] i_bit_mask,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_global_write_protect,
    input wire logic i_stop_release,
    input wire logic i_snooze_exit,
    input wire logic i_first_latch_wr,
    input wire logic i_first_latch_val,
    input wire logic i_second_latch_wr,
    input wire logic i_second_latch_val,
    output logic o_first_candidate_port_pin,
    output logic o_second_candidate_port_pin,
    output logic o_wake_output_enable,
    output logic o_wake_output_level
);
    // ------------------------------------------------------------
    // Bus request bundle
    // ------------------------------------------------------------
    ssoc_req_s req;
    assign req = '{addr: i_addr, wdata: i_wdata, bit_mask: i_bit_mask,
                   wr: i_wr, rd: i_rd};

    // Control register and read data
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] rdata_q, rdata_d;
    // Wake event pending one cycle, captured selection
    ssoc_pin_s upd_q, upd_d;
    // Decoded hits
    logic hit;
    logic wake_ev;
    logic [7:0] writable;
    logic [7:0] merged;
    // Final next value with the level bit settled
    logic [7:0] ctrl_d_fix;

    // ------------------------------------------------------------
    // Address decode and write merge
    // ------------------------------------------------------------
    always_comb begin
        hit = 1'b0;
        if (req.addr == SSOC_CTRL_ADDR) begin
            hit = 1'b1;
        end
        // Unused bits never writable, select reserved in the small package
        writable = SSOC_IMPL_MASK;
        if (SMALL_PACKAGE) begin
            writable[SSOC_BIT_SELECT] = 1'b0;
        end
        // Only addressed bits change on a bit write
        merged = (ctrl_q & ~req.bit_mask) | (req.wdata & req.bit_mask);
        wake_ev = i_stop_release | i_snooze_exit;
    end

    // ------------------------------------------------------------
    // Control register next value
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        if (req.wr && hit && !i_global_write_protect) begin
            ctrl_d = merged & writable;
        end
        // Level bit is settled in ctrl_d_fix, where the toggle
        // wins over a simultaneous write
    end

    // ------------------------------------------------------------
    // Wake event staging: latch load and toggle share one cycle
    // ------------------------------------------------------------
    // upd_q.load marks a pin load, upd_q.select reused only with load;
    // a toggle-only request uses a separate flag below
    logic tog_q, tog_d;
    always_comb begin
        upd_d = '0;
        tog_d = wake_ev;
        // Drive only on stop release with enable set
        if (i_stop_release && ctrl_q[SSOC_BIT_ENABLE]) begin
            upd_d.load = 1'b1;
            upd_d.select = ctrl_q[SSOC_BIT_SELECT];
        end
        upd_d.level = ctrl_q[SSOC_BIT_LEVEL];
    end

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        if (req.rd && hit) begin
            rdata_d = ctrl_q;
        end
    end

    // Register control, read data and wake staging state
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= SSOC_CTRL_RESET;
            rdata_q <= 8'h00;
            upd_q <= '0;
            tog_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d_fix;
            rdata_q <= rdata_d;
            upd_q <= upd_d;
            tog_q <= tog_d;
        end
    end

    // Toggle applied in the cycle the pin is loaded
    always_comb begin
        ctrl_d_fix = ctrl_d;
        ctrl_d_fix[SSOC_BIT_LEVEL] = ctrl_q[SSOC_BIT_LEVEL];
        if (req.wr && hit && !i_global_write_protect) begin
            ctrl_d_fix[SSOC_BIT_LEVEL] = merged[SSOC_BIT_LEVEL];
        end
        if (tog_q) begin
            ctrl_d_fix[SSOC_BIT_LEVEL] = ~ctrl_q[SSOC_BIT_LEVEL];
        end
    end

    // ------------------------------------------------------------
    // Port latch stage
    // ------------------------------------------------------------
    ssoc_pin_latch u_latch (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_upd(upd_q),
        .i_sw_first_wr(i_first_latch_wr),
        .i_sw_first_val(i_first_latch_val),
        .i_sw_second_wr(i_second_latch_wr),
        .i_sw_second_val(i_second_latch_val),
        .o_first_candidate_port_pin(o_first_candidate_port_pin),
        .o_second_candidate_port_pin(o_second_candidate_port_pin)
    );

    assign o_rdata = rdata_q;
    assign o_wake_output_enable = ctrl_q[SSOC_BIT_ENABLE];
    assign o_wake_output_level = ctrl_q[SSOC_BIT_LEVEL];

    // ------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------
    // A write that the register takes this cycle
    logic wr_ok;
    // Wake events of the last two cycles, newest in bit 0
    logic [1:0] wake_hist_q, wake_hist_d;
    // Enabled stop releases of the last two cycles, newest in bit 0
    logic [1:0] load_hist_q, load_hist_d;

    // Accepted write and event history
    always_comb begin
        wr_ok = req.wr && hit && !i_global_write_protect;
        wake_hist_d = {wake_hist_q[0], wake_ev};
        load_hist_d = {load_hist_q[0],
                       i_stop_release && ctrl_q[SSOC_BIT_ENABLE]};
    end

    // Shift the history along, cleared by reset
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wake_hist_q <= 2'b00;
            load_hist_q <= 2'b00;
        end else begin
            wake_hist_q <= wake_hist_d;
            load_hist_q <= load_hist_d;
        end
    end

    // ------------------------------------------------------------
    // Register access checks
    // ------------------------------------------------------------
    // Read data is the register of the strobe cycle
    a_read_data: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        i_rd && i_addr == SSOC_CTRL_ADDR |=> o_rdata == $past(ctrl_q))
        else $error("read data wrong");
    // Without a read hit the read data rests at zero
    a_rdata_idle: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        !(i_rd && hit) |=> o_rdata == 8'h00)
        else $error("read data not zero");
    // A byte write lands with the unimplemented bits cleared
    a_write_lands: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        wr_ok && !tog_q && (&i_bit_mask)
        |=> ctrl_q == ($past(i_wdata) & writable))
        else $error("byte write lost");
    // A write that leaves the enable lane out keeps the enable bit
    a_bit_keep: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        wr_ok && !i_bit_mask[SSOC_BIT_ENABLE]
        |=> $stable(ctrl_q[SSOC_BIT_ENABLE]))
        else $error("bit write touched other bit");

    // ------------------------------------------------------------
    // Write protect checks
    // ------------------------------------------------------------
    // Protected write leaves the register as it was
    a_protect_hold: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        i_wr && i_global_write_protect && !tog_q |=> $stable(ctrl_q))
        else $error("write under protect changed register");
    // Enable bit moves only on a taken write
    a_protect_enable: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        !wr_ok |=> $stable(ctrl_q[SSOC_BIT_ENABLE]))
        else $error("enable changed without write");

    // ------------------------------------------------------------
    // Wake staging checks
    // ------------------------------------------------------------
    // Level bit flips two edges after each wake event
    a_level_toggle: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        wake_ev |=> ##1 ctrl_q[SSOC_BIT_LEVEL] != $past(ctrl_q[SSOC_BIT_LEVEL]))
        else $error("level not toggled");
    // Same flip, seen through the event history
    a_hist_toggle: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        wake_hist_q[1]
        |-> ctrl_q[SSOC_BIT_LEVEL] != $past(ctrl_q[SSOC_BIT_LEVEL]))
        else $error("level not flipped after event");
    // Toggle request always flips the level bit, even over a write
    a_toggle_apply: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        tog_q |=> ctrl_q[SSOC_BIT_LEVEL] != $past(ctrl_q[SSOC_BIT_LEVEL]))
        else $error("toggle request lost");
    // Stop release with enable clear loads nothing
    a_no_enable: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        i_stop_release && !ctrl_q[SSOC_BIT_ENABLE] |=> !upd_q.load)
        else $error("pin load without enable");
    // Snooze exit alone never loads a pin
    a_snooze_no_load: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        i_snooze_exit && !i_stop_release |=> !upd_q.load)
        else $error("pin load on snooze exit");
    // Every wake event raises the toggle request
    a_wake_stage: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        wake_ev |=> tog_q)
        else $error("toggle request missing");
    // Pin load never comes without its toggle
    a_load_with_toggle: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        upd_q.load |-> tog_q)
        else $error("load and toggle apart");
    // Level bit flips on the edge that loads the pin
    a_load_flip: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        upd_q.load |=> ctrl_q[SSOC_BIT_LEVEL] != $past(ctrl_q[SSOC_BIT_LEVEL]))
        else $error("load without level flip");

    // ------------------------------------------------------------
    // Pin routing checks
    // ------------------------------------------------------------
    // Enabled release with select zero loads the first pin
    a_pin_first: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        load_hist_q[1] && !$past(ctrl_q[SSOC_BIT_SELECT], 2) |->
        o_first_candidate_port_pin == $past(ctrl_q[SSOC_BIT_LEVEL], 2))
        else $error("first pin level wrong");
    // Enabled release with select one loads the second pin
    a_pin_second: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        load_hist_q[1] && $past(ctrl_q[SSOC_BIT_SELECT], 2) |->
        o_second_candidate_port_pin == $past(ctrl_q[SSOC_BIT_LEVEL], 2))
        else $error("second pin level wrong");
    // First pin holds unless loaded or written
    a_pin_keep: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        !upd_q.load && !i_first_latch_wr
        |=> $stable(o_first_candidate_port_pin))
        else $error("first pin moved by itself");
    // Second pin holds unless loaded or written
    a_pin_hold: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        !upd_q.load && !i_second_latch_wr
        |=> $stable(o_second_candidate_port_pin))
        else $error("second pin moved by itself");

    // ------------------------------------------------------------
    // Reset and reserved bit checks
    // ------------------------------------------------------------
    // Unused bits read and stay zero
    a_unused_zero: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (ctrl_q & ~SSOC_IMPL_MASK) == 8'h00)
        else $error("unused bit set");
    // Reserved select bit stays zero in the small package
    a_small_select: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        SMALL_PACKAGE |-> !ctrl_q[SSOC_BIT_SELECT])
        else $error("reserved select set");
    // Register is clear at the first edge after reset
    a_reset_zero: assert property (
        @(posedge i_ref_clk)
        $rose(i_reset_n) |-> ctrl_q == SSOC_CTRL_RESET)
        else $error("register not cleared");
endmodule : ssoc_top

// ### include/ssoc_pkg.sv
// Package: register map, field layout and types for the stop status output
package ssoc_pkg;
    // Register byte address of the control register
    localparam logic [19:0] SSOC_CTRL_ADDR = 20'hF02CA;
    // Reset value of the control register
    localparam logic [7:0] SSOC_CTRL_RESET = 8'h00;
    // Field positions
    localparam int SSOC_BIT_ENABLE = 7;
    localparam int SSOC_BIT_LEVEL = 4;
    localparam int SSOC_BIT_SELECT = 0;
    // Mask of implemented bits (all others read zero)
    localparam logic [7:0] SSOC_IMPL_MASK = 8'h91;
    // Pin select values
    localparam logic SSOC_SEL_FIRST = 1'b0;
    localparam logic SSOC_SEL_SECOND = 1'b1;

    // Register bus request
    typedef struct packed {
        logic [19:0] addr;
        logic [7:0] wdata;
        logic [7:0] bit_mask;
        logic wr;
        logic rd;
    } ssoc_req_s;

    // Latch update request toward the pin stage
    typedef struct packed {
        logic load;
        logic level;
        logic select;
    } ssoc_pin_s;
endpackage : ssoc_pkg

// ### testbench/ssoc_pin_watch.sv
// Partner model: outside circuit counting rises on the two status pins
`timescale 1ns/1ps
module ssoc_pin_watch (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_first_pin,
    input wire logic i_second_pin,
    output logic [7:0] o_rises
);
    logic [1:0] last_q; // Pin levels one cycle ago
    logic [1:0] rise; // Low to high seen this cycle
    assign rise = {i_first_pin, i_second_pin} & ~last_q;
    // Count every low to high step of either pin
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            last_q <= 2'b00;
            o_rises <= 8'h00;
        end else begin
            last_q <= {i_first_pin, i_second_pin};
            o_rises <= o_rises + {7'h00, rise[1]} + {7'h00, rise[0]};
        end
    end
endmodule : ssoc_pin_watch

// ### testbench/tb_ssoc_top.sv
// Testbench: register access, write protect and wake status output
`timescale 1ns/1ps
module tb_ssoc_top
    import ssoc_pkg::*;
;
    // --------------------------------------------------------------
    // Stimulus and observed signals
    // --------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [19:0] addr = 20'h00000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] mask = 8'h00;
    logic wr = 1'b0, rd = 1'b0, prot = 1'b0, lat_wr = 1'b0;
    logic stop_ev = 1'b0, snz_ev = 1'b0, rd_seen = 1'b0;
    logic [7:0] rdata, rises, exp_rises;
    logic [7:0] rdata_s, exp_rd, pins_seen; // Small variant, read note
    logic pin1, pin2, en_o, lv_o;
    logic [7:0] exp_q[$]; // Expected read data, oldest first
    logic [7:0] exp_pin[$], exp_rise[$]; // Expected pin state, rises
    logic look = 1'b0; // Pin state ready to compare
    assign pins_seen = {4'h0, en_o, lv_o, pin1, pin2};
    int errors = 0, comparisons = 0, cycles = 0;
    always #10 ref_clk = ~ref_clk;
    ssoc_top u_dut (
        .i_ref_clk(ref_clk),
        .i_reset_n(reset_n),
        .i_addr(addr),
        .i_wdata(wdata),
        .i_bit_mask(mask),
        .i_wr(wr),
        .i_rd(rd),
        .o_rdata(rdata),
        .i_global_write_protect(prot),
        .i_stop_release(stop_ev),
        .i_snooze_exit(snz_ev),
        .i_first_latch_wr(lat_wr),
        .i_first_latch_val(1'b0),
        .i_second_latch_wr(lat_wr),
        .i_second_latch_val(1'b0),
        .o_first_candidate_port_pin(pin1),
        .o_second_candidate_port_pin(pin2),
        .o_wake_output_enable(en_o),
        .o_wake_output_level(lv_o)
    );
    // Small package variant on the same bus
    ssoc_top #(
        .SMALL_PACKAGE(1'b1)
    ) u_dut_small (
        .i_ref_clk(ref_clk),
        .i_reset_n(reset_n),
        .i_addr(addr),
        .i_wdata(wdata),
        .i_bit_mask(mask),
        .i_wr(wr),
        .i_rd(rd),
        .o_rdata(rdata_s),
        .i_global_write_protect(prot),
        .i_stop_release(stop_ev),
        .i_snooze_exit(snz_ev),
        .i_first_latch_wr(lat_wr),
        .i_first_latch_val(1'b0),
        .i_second_latch_wr(lat_wr),
        .i_second_latch_val(1'b0),
        .o_first_candidate_port_pin(),
        .o_second_candidate_port_pin(),
        .o_wake_output_enable(),
        .o_wake_output_level()
    );
    ssoc_pin_watch u_watch (
        .i_ref_clk(ref_clk),
        .i_reset_n(reset_n),
        .i_first_pin(pin1),
        .i_second_pin(pin2),
        .o_rises(rises)
    );
    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    // One write cycle, then one idle cycle
    task automatic bus_wr(input logic [7:0] d, input logic [7:0] m);
        addr <= SSOC_CTRL_ADDR;
        wdata <= d;
        mask <= m;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask : bus_wr
    // One read cycle; the expected data waits in the queue
    task automatic bus_rd(input logic [19:0] a, input logic [7:0] e);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk);
        rd <= 1'b0;
        @(posedge ref_clk);
    endtask : bus_rd
    // Read data stands only in the cycle after the strobe
    always @(posedge ref_clk) rd_seen <= rd;
    always @(negedge ref_clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            exp_rd = exp_q.pop_front();
            check(rdata, exp_rd);
            check(rdata_s, exp_rd & ~(8'h01 << SSOC_BIT_SELECT));
        end
        if (look && exp_pin.size() > 0) begin
            check(pins_seen, exp_pin.pop_front());
        end
        if (look && exp_rise.size() > 0) begin
            check(rises, exp_rise.pop_front());
        end
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            test_done();
        end
    end
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        logic [7:0] r, v;
        logic stop, p1, p2;
        r = 8'($urandom(32'hD652AA83));
        exp_rises = 8'h00;
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        bus_rd(SSOC_CTRL_ADDR, SSOC_CTRL_RESET);
        bus_wr(8'hFF, 8'hFF);
        bus_rd(SSOC_CTRL_ADDR, 8'h91);
        bus_rd(SSOC_CTRL_ADDR + 20'h00001, 8'h00);
        bus_wr(8'h00, 8'h10);
        bus_rd(SSOC_CTRL_ADDR, 8'h81);
        prot <= 1'b1;
        bus_wr(8'($urandom()), 8'hFF);
        bus_rd(SSOC_CTRL_ADDR, 8'h81);
        prot <= 1'b0;
        // Every enable, level and select with stop or snooze exit
        for (int i = 0; i < 16; i++) begin
            r = 8'($urandom());
            v = {i[2], 2'b00, i[1], 3'b000, i[0]};
            stop = i[3] ^ r[0];
            p1 = stop & v[7] & v[4] & ~v[0];
            p2 = stop & v[7] & v[4] & v[0];
            exp_rises = exp_rises + {7'h00, p1 | p2};
            lat_wr <= 1'b1;
            @(posedge ref_clk);
            lat_wr <= 1'b0;
            bus_wr(v, 8'hFF);
            stop_ev <= stop;
            snz_ev <= ~stop;
            @(posedge ref_clk);
            stop_ev <= 1'b0;
            snz_ev <= 1'b0;
            // Expected pin state and rise count after the wake walk
            exp_pin.push_back({4'h0, v[7], ~v[4], p1, p2});
            exp_rise.push_back(exp_rises);
            repeat (3) @(posedge ref_clk);
            look <= 1'b1;
            @(posedge ref_clk);
            look <= 1'b0;
            bus_rd(SSOC_CTRL_ADDR, v ^ 8'h10);
        end
        test_done();
    end
endmodule : tb_ssoc_top
